// file: include/lpm_pkg.sv
// Constants, register map and types of the panel standby power manager
package lpm_pkg;
    // Clock and timing figures
    localparam int CLK_HZ             = 25_000_000;
    localparam int MINUTE_S           = 60;
    localparam int MINUTE_CYCLES      = MINUTE_S * CLK_HZ;
    localparam int STEP_DELAY_US      = 10_000;
    localparam int STEP_CYCLES        = STEP_DELAY_US * (CLK_HZ / 1_000_000);
    localparam int STATUS_HOLD_US     = 32;
    localparam int STATUS_HOLD_CYCLES =
        (STATUS_HOLD_US * CLK_HZ + 999_999) / 1_000_000;

    // Register indices; byte address is index times four
    localparam logic [3:0] IDX_POWER_CONTROL  = 4'h0;
    localparam logic [3:0] IDX_TIMER_CONFIG   = 4'h1;
    localparam logic [3:0] IDX_PANEL_OVERRIDE = 4'h2;
    localparam logic [3:0] IDX_POWER_STATUS   = 4'h3;
    localparam logic [3:0] IDX_ACT_RESET_EN   = 4'h4;
    localparam logic [3:0] IDX_VOLTAGE_SELECT = 4'h5;
    localparam logic [3:0] IDX_PIN_FUNCTION   = 4'h6;
    localparam logic [3:0] IDX_FEATURE_SELECT = 4'h7;
    localparam logic [3:0] IDX_KBD_ENABLE     = 4'h8;
    localparam int         REG_COUNT          = 9;
    localparam logic [7:0] REG_RESET          = 8'h00;

    // Field positions
    localparam int BIT_SW_STANDBY  = 4;
    localparam int BL_TIMEOUT_LSB  = 4;
    localparam int SBY_TIMEOUT_LSB = 0;
    localparam int BIT_BL_OVR      = 3;
    localparam int BIT_BL_VAL      = 2;
    localparam int BIT_SUP_OVR     = 1;
    localparam int BIT_SUP_VAL     = 0;
    localparam int BIT_ACT_SBY     = 6;
    localparam int BIT_ACC_SBY     = 5;
    localparam int BIT_ACT_BL      = 3;
    localparam int BIT_ACC_BL      = 2;
    localparam int BIT_CORE_5V     = 7;
    localparam int BIT_PIN_SEL     = 6;
    localparam int BIT_FC_SEL      = 7;
    localparam int BIT_KBD_SBY     = 1;
    localparam int BIT_KBD_BL      = 0;

    typedef enum logic [2:0] {
        SEQ_OFF          = 3'b000,
        SEQ_UP_SUPPLY    = 3'b001,
        SEQ_UP_CONTRAST  = 3'b010,
        SEQ_ON           = 3'b011,
        SEQ_DN_BACKLIGHT = 3'b100,
        SEQ_DN_CONTRAST  = 3'b101
    } lpm_seq_type;

    typedef struct packed {
        logic [3:0] idx;
        logic       hit;
        logic       write;
    } lpm_bus_req_type;
endpackage

// file: rtl/lpm_power_manager.sv
// Panel power sequencer, standby control and idle timers with AHB registers

// Minute-based idle timer, restarted by activity or a new timeout
module lpm_idle_timer
    import lpm_pkg::*;
(
    input  wire logic       clk_sys,
    input  wire logic       rst_n,
    input  wire logic       tick,
    input  wire logic [3:0] timeout,
    input  wire logic       restart,
    output logic            expired
);
    logic [3:0] remaining;
    logic [3:0] loaded;

    // Zero timeout never expires; restart keeps the free minute phase
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            remaining <= 4'h0;
            loaded    <= 4'h0;
            expired   <= 1'b0;
        end else if (restart || timeout != loaded) begin
            remaining <= timeout;
            loaded    <= timeout;
            expired   <= 1'b0;
        end else if (tick && remaining != 4'h0) begin
            remaining <= remaining - 4'h1;
            expired   <= (remaining == 4'h1);
        end
    end
endmodule

////////////////////////////////////////////////////////////////////////////
// Operation
// - Supply, contrast and backlight outputs sequence on power, CRT/LCD, standby.
// - Activity edge, keyboard or host access restart backlight timer if enabled.
// - Backlight override bit drives backlight from a software value bit.
// - Supply override bit drives panel supply from a software value bit.
// - Core voltage select output follows its control bit.
// - Standby status high from clock stop to 32 us after restart.
// - Feature connector configured and selected puts pixel data on status pins.
// - 24-bit TFT puts green bits 0 and 1 on the status pins.
// - Suspend status pin low while suspend status field is nonzero.
// - Normal mode powers displays and keeps clocks and access running.
// - Standby stops video clock, gates CRT controller clock, RAMDAC low power.
// - Standby keeps slow memory refresh and CPU access running.
// - Entering or leaving standby starts panel power-down or power-up.
// - Software standby bit set starts standby power-down.
// - Standby idle timer in minutes up to 15; expiry enters standby.
// - Standby pin high enters standby when both select bits are zero.
// - Standby lasts until every active entry condition is removed.
// - A running power sequence completes before any new request acts.
// - Shared pin is activity input only when both select bits are one.
module lpm_power_manager
    import lpm_pkg::*;
#(
    parameter int MINUTE_TICKS = MINUTE_CYCLES,
    parameter int STEP_TICKS   = STEP_CYCLES
)
(
    input  wire logic        clk_sys,
    input  wire logic        rst_n,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        sense_pin_in,
    input  wire logic        feature_connector_strap,
    input  wire logic        keyboard_activity_in,
    input  wire logic        host_access_in,
    input  wire logic        lcd_enable_in,
    input  wire logic [1:0]  suspend_mode_in,
    input  wire logic        tft24_connected_in,
    input  wire logic [1:0]  fc_pixel_in,
    input  wire logic [1:0]  green_data_in,
    output logic             panel_supply_out,
    output logic             panel_contrast_supply_out,
    output logic             panel_backlight_out,
    output logic             core_voltage_select_out,
    output logic             standby_status_n,
    output logic             suspend_status_n,
    output logic             video_clock_enable,
    output logic             crtc_clock_enable,
    output logic             ramdac_low_power,
    output logic             refresh_slow
);
    logic            rst_meta_n, rst_sync_n;
    logic            sense_meta, sense_sync, sense_prev;
    logic            strap_meta, fc_configured;
    logic [7:0]      ctl [REG_COUNT];
    lpm_bus_req_type req;
    logic            data_phase;
    logic [7:0]      read_value;
    logic [31:0]     minute_cnt;
    logic            minute_tick;
    logic            act_edge, act_en, pin_standby;
    logic            sby_restart, bl_restart, sby_expired, bl_expired;
    logic            standby_req, want_on, clock_stopped, sby_stat;
    logic [9:0]      hold_cnt;
    lpm_seq_type     state;
    logic [31:0]     step_cnt;
    logic            seq_supply, seq_contrast, seq_backlight;

    ////////////////////////////////////////////////////////////////////////
    // Reset release and pin synchronisers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // Strap is static, so following it continuously catches it after reset
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            sense_meta    <= 1'b0;
            sense_sync    <= 1'b0;
            sense_prev    <= 1'b0;
            strap_meta    <= 1'b0;
            fc_configured <= 1'b0;
        end else begin
            sense_meta    <= sense_pin_in;
            sense_sync    <= sense_meta;
            sense_prev    <= sense_sync;
            strap_meta    <= feature_connector_strap;
            fc_configured <= strap_meta;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave: one wait state per transfer, always OKAY
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hreadyout  <= 1'b1;
            hresp      <= 1'b0;
            hrdata     <= 32'h0000_0000;
            data_phase <= 1'b0;
            req        <= '0;
        end else if (data_phase) begin
            data_phase <= 1'b0;
            hreadyout  <= 1'b1;
            hrdata     <= (req.hit && !req.write) ? {24'h00_0000, read_value}
                                                  : 32'h0000_0000;
        end else if (hsel && htrans[1] && hready) begin
            req.idx    <= haddr[5:2];
            req.hit    <= (haddr[31:6] == 26'h000_0000) &&
                          (haddr[5:2] < 4'(REG_COUNT));
            req.write  <= hwrite;
            data_phase <= 1'b1;
            hreadyout  <= 1'b0;
        end
    end

    // Status is read-only; unmapped reads give zero
    always_comb begin
        if (req.idx == IDX_POWER_STATUS) begin
            read_value = {suspend_mode_in, 1'b0, sby_stat, 1'b0, state};
        end else begin
            read_value = ctl[req.idx];
        end
    end

    // Control registers take the low byte of the write data
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                ctl[i] <= REG_RESET;
            end
        end else if (data_phase && req.hit && req.write &&
                     req.idx != IDX_POWER_STATUS) begin
            ctl[req.idx] <= hwdata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Activity sources and idle timers
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            minute_cnt  <= 32'h0000_0000;
            minute_tick <= 1'b0;
        end else begin
            minute_tick <= (minute_cnt == 32'(MINUTE_TICKS - 1));
            minute_cnt  <= (minute_cnt == 32'(MINUTE_TICKS - 1))
                           ? 32'h0000_0000 : minute_cnt + 32'h1;
        end
    end

    assign act_en      = ctl[IDX_FEATURE_SELECT][BIT_FC_SEL] &&
                         ctl[IDX_PIN_FUNCTION][BIT_PIN_SEL];
    assign act_edge    = act_en && sense_sync && !sense_prev;
    assign pin_standby = !ctl[IDX_FEATURE_SELECT][BIT_FC_SEL] &&
                         !ctl[IDX_PIN_FUNCTION][BIT_PIN_SEL] && sense_sync;
    assign bl_restart  =
        (act_edge && ctl[IDX_ACT_RESET_EN][BIT_ACT_BL]) ||
        (host_access_in && ctl[IDX_ACT_RESET_EN][BIT_ACC_BL]) ||
        (keyboard_activity_in && ctl[IDX_KBD_ENABLE][BIT_KBD_BL]);
    assign sby_restart =
        (act_edge && ctl[IDX_ACT_RESET_EN][BIT_ACT_SBY]) ||
        (host_access_in && ctl[IDX_ACT_RESET_EN][BIT_ACC_SBY]) ||
        (keyboard_activity_in && ctl[IDX_KBD_ENABLE][BIT_KBD_SBY]);

    lpm_idle_timer u_standby_timer (
        .clk_sys (clk_sys),
        .rst_n   (rst_sync_n),
        .tick    (minute_tick),
        .timeout (ctl[IDX_TIMER_CONFIG][SBY_TIMEOUT_LSB +: 4]),
        .restart (sby_restart),
        .expired (sby_expired)
    );

    lpm_idle_timer u_backlight_timer (
        .clk_sys (clk_sys),
        .rst_n   (rst_sync_n),
        .tick    (minute_tick),
        .timeout (ctl[IDX_TIMER_CONFIG][BL_TIMEOUT_LSB +: 4]),
        .restart (bl_restart),
        .expired (bl_expired)
    );

    ////////////////////////////////////////////////////////////////////////
    // software entry; any active source holds standby
    assign standby_req = ctl[IDX_POWER_CONTROL][BIT_SW_STANDBY] ||
                         sby_expired || pin_standby;
    assign want_on     = lcd_enable_in && !standby_req;

    // clocks stop once the panel is off, status held 32 us after restart
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            clock_stopped <= 1'b0;
            hold_cnt      <= 10'h000;
            sby_stat      <= 1'b0;
        end else begin
            if (standby_req && state == SEQ_OFF) begin
                clock_stopped <= 1'b1;
            end else if (!standby_req) begin
                clock_stopped <= 1'b0;
            end
            if (clock_stopped && !standby_req) begin
                hold_cnt <= 10'(STATUS_HOLD_CYCLES);
            end else if (hold_cnt != 10'h000) begin
                hold_cnt <= hold_cnt - 10'h1;
            end
            sby_stat <= clock_stopped || (hold_cnt > 10'h001);
        end
    end

    // panel follows standby; steps finish before retargeting
    // supply, contrast, backlight with a fixed delay between steps
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            state    <= SEQ_OFF;
            step_cnt <= 32'h0000_0000;
        end else begin
            step_cnt <= (step_cnt != 32'h0) ? step_cnt - 32'h1 : step_cnt;
            case (state)
                SEQ_OFF: begin
                    if (want_on && !clock_stopped) begin
                        state    <= SEQ_UP_SUPPLY;
                        step_cnt <= 32'(STEP_TICKS - 1);
                    end
                end
                SEQ_UP_SUPPLY: begin
                    if (step_cnt == 32'h0) begin
                        state    <= SEQ_UP_CONTRAST;
                        step_cnt <= 32'(STEP_TICKS - 1);
                    end
                end
                SEQ_UP_CONTRAST: begin
                    if (step_cnt == 32'h0) begin
                        state <= SEQ_ON;
                    end
                end
                SEQ_ON: begin
                    if (!want_on) begin
                        state    <= SEQ_DN_BACKLIGHT;
                        step_cnt <= 32'(STEP_TICKS - 1);
                    end
                end
                SEQ_DN_BACKLIGHT: begin
                    if (step_cnt == 32'h0) begin
                        state    <= SEQ_DN_CONTRAST;
                        step_cnt <= 32'(STEP_TICKS - 1);
                    end
                end
                SEQ_DN_CONTRAST: begin
                    if (step_cnt == 32'h0) begin
                        state <= SEQ_OFF;
                    end
                end
                default: begin
                    state <= SEQ_OFF;
                end
            endcase
        end
    end

    assign seq_supply    = (state != SEQ_OFF);
    assign seq_contrast  = (state == SEQ_UP_CONTRAST) || (state == SEQ_ON) ||
                           (state == SEQ_DN_BACKLIGHT);
    assign seq_backlight = (state == SEQ_ON);

    ////////////////////////////////////////////////////////////////////////
    // Registered pin outputs; overrides can harm the panel, use with care
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            panel_supply_out          <= 1'b0;
            panel_contrast_supply_out <= 1'b0;
            panel_backlight_out       <= 1'b0;
            core_voltage_select_out   <= 1'b0;
        end else begin
            panel_supply_out <= ctl[IDX_PANEL_OVERRIDE][BIT_SUP_OVR]
                                ? ctl[IDX_PANEL_OVERRIDE][BIT_SUP_VAL]
                                : seq_supply;
            panel_contrast_supply_out <= seq_contrast;
            // backlight override, else sequencer gated by idle timer
            panel_backlight_out <= ctl[IDX_PANEL_OVERRIDE][BIT_BL_OVR]
                                   ? ctl[IDX_PANEL_OVERRIDE][BIT_BL_VAL]
                                   : seq_backlight && !bl_expired;
            core_voltage_select_out <= ctl[IDX_VOLTAGE_SELECT][BIT_CORE_5V];
        end
    end

    // clock gating and RAMDAC; refresh and access continue
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            video_clock_enable <= 1'b1;
            crtc_clock_enable  <= 1'b1;
            ramdac_low_power   <= 1'b0;
            refresh_slow       <= 1'b0;
        end else begin
            video_clock_enable <= !clock_stopped;
            crtc_clock_enable  <= !clock_stopped;
            ramdac_low_power   <= clock_stopped;
            refresh_slow       <= clock_stopped;
        end
    end

    // status pin function, TFT data takes priority
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            standby_status_n <= 1'b1;
            suspend_status_n <= 1'b1;
        end else if (tft24_connected_in) begin
            standby_status_n <= green_data_in[0];
            suspend_status_n <= green_data_in[1];
        end else if (fc_configured && ctl[IDX_FEATURE_SELECT][BIT_FC_SEL]) begin
            standby_status_n <= fc_pixel_in[0];
            suspend_status_n <= fc_pixel_in[1];
        end else begin
            standby_status_n <= !sby_stat;
            suspend_status_n <= (suspend_mode_in == 2'b00);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_sync_n);

    logic pins_normal;
    assign pins_normal = !tft24_connected_in &&
        !(fc_configured && ctl[IDX_FEATURE_SELECT][BIT_FC_SEL]);

    sequence s_restart;
        $fell(clock_stopped);
    endsequence
    sequence s_held_low;
        (sby_stat && hold_cnt != 10'h000) [*8];
    endsequence

    a_status_hold: assert property (s_restart |=> s_held_low)
        else $error("standby status dropped early after restart");
    a_supply_ovr: assert property (ctl[IDX_PANEL_OVERRIDE][BIT_SUP_OVR]
        |=> panel_supply_out == $past(ctl[IDX_PANEL_OVERRIDE][BIT_SUP_VAL]))
        else $error("supply override not obeyed");
    a_backlight_ovr: assert property (ctl[IDX_PANEL_OVERRIDE][BIT_BL_OVR]
        |=> panel_backlight_out == $past(ctl[IDX_PANEL_OVERRIDE][BIT_BL_VAL]))
        else $error("backlight override not obeyed");
    a_backlight_idle: assert property (bl_expired &&
        !ctl[IDX_PANEL_OVERRIDE][BIT_BL_OVR] |=> !panel_backlight_out)
        else $error("backlight on after idle expiry");
    a_core_voltage: assert property (##1 core_voltage_select_out ==
        $past(ctl[IDX_VOLTAGE_SELECT][BIT_CORE_5V]))
        else $error("core voltage select wrong");
    a_standby_down: assert property (state == SEQ_ON && standby_req
        |=> state == SEQ_DN_BACKLIGHT)
        else $error("standby did not start power-down");
    a_step_finish: assert property (state == SEQ_UP_SUPPLY &&
        step_cnt != 32'h0 |=> state == SEQ_UP_SUPPLY)
        else $error("power-up step cut short");
    a_pin_standby: assert property (pin_standby && state == SEQ_OFF
        |=> clock_stopped)
        else $error("standby pin ignored");
    a_tft_green: assert property (tft24_connected_in |=>
        standby_status_n == $past(green_data_in[0]) &&
        suspend_status_n == $past(green_data_in[1]))
        else $error("status pins not carrying green data");
    a_suspend_pin: assert property (pins_normal &&
        suspend_mode_in != 2'b00 |=> !suspend_status_n)
        else $error("suspend status pin not low");
    a_clock_stop: assert property (clock_stopped |=> !video_clock_enable &&
        !crtc_clock_enable && ramdac_low_power && refresh_slow)
        else $error("standby clocks not stopped");
endmodule

// file: verification/lcd_standby_power_manager_bench.sv
// Self-checking bench of the panel standby power manager
module lcd_standby_power_manager_bench;
    timeunit 1ns;
    timeprecision 1ns;

    typedef struct packed {
        logic [31:0] a;
        logic [7:0]  d;
        logic [7:0]  r;
        logic        c;
    } lpm_row_type;

    logic        clk_sys = 1'h0;
    logic        rst_n   = 1'h0;
    logic        hsel    = 1'h0;
    logic        hwrite  = 1'h0;
    logic [1:0]  htrans  = 2'h0;
    logic [31:0] haddr   = 32'h0;
    logic [31:0] hwdata  = 32'h0;
    logic        sense   = 1'h0;
    logic        tft     = 1'h0;
    logic [1:0]  susp    = 2'h0;
    logic [1:0]  green   = 2'h0;
    logic        lcd     = 1'h1;
    logic        kbd     = 1'h0;
    logic        host    = 1'h0;
    logic        hreadyout, hresp, sup, con, bl, core, sby_n, susp_n;
    logic        video_clock_en, crtc_en, rdac_lp, rf_slow, fault;
    logic [31:0] hrdata, rd;
    int          miscompares = 0;
    int          n_checks    = 0;
    int          i;
    int          j;
    lpm_row_type rows [6] = '{
        '{32'h0C, 8'hFF, 8'h03, 1'h0}, '{32'h14, 8'h80, 8'h80, 1'h1},
        '{32'h14, 8'h00, 8'h00, 1'h0}, '{32'h24, 8'hFF, 8'h00, 1'h0},
        '{32'h18, 8'h40, 8'h40, 1'h0}, '{32'h18, 8'h00, 8'h00, 1'h0}};

    // Short counts keep the run small
    lpm_power_manager #(.MINUTE_TICKS(20), .STEP_TICKS(8)) u_lpm_power_manager (
        .clk_sys(clk_sys), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .sense_pin_in(sense),
        .feature_connector_strap(1'h1), .keyboard_activity_in(kbd),
        .host_access_in(host), .lcd_enable_in(lcd),
        .suspend_mode_in(susp), .tft24_connected_in(tft),
        .fc_pixel_in(2'h3), .green_data_in(green),
        .panel_supply_out(sup), .panel_contrast_supply_out(con),
        .panel_backlight_out(bl), .core_voltage_select_out(core),
        .standby_status_n(sby_n), .suspend_status_n(susp_n),
        .video_clock_enable(video_clock_en), .crtc_clock_enable(crtc_en),
        .ramdac_low_power(rdac_lp), .refresh_slow(rf_slow));

    lpm_panel_model u_lpm_panel_model (
        .clk_sys(clk_sys), .supply(sup), .contrast(con),
        .backlight(bl), .order_fault(fault));

    // 25 MHz system clock
    always #20 clk_sys = ~clk_sys;

    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic print_verdict();
        if (miscompares == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Ready is registered, so its negedge value is what the edge samples
    task automatic await_ready();
        int k;
        for (k = 0; k < 40; k++) begin
            @(negedge clk_sys);
            rd = hrdata;
            if (hreadyout === 1'h1) break;
            @(posedge clk_sys);
        end
        if (k == 40) begin
            miscompares++;
            print_verdict();
        end else begin
            @(posedge clk_sys);
        end
    endtask

    task automatic bus(input logic [31:0] a, input logic w,
                       input logic [31:0] d);
        @(posedge clk_sys);
        hsel   <= 1'h1;
        haddr  <= a;
        htrans <= 2'h2;
        hwrite <= w;
        await_ready();
        hsel   <= 1'h0;
        htrans <= 2'h0;
        hwdata <= d;
        await_ready();
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Main sequence; waits poll at negedge where outputs have settled
    initial begin
        repeat (5) @(negedge clk_sys);
        chk("reset outs", 32'h3C, {sup, con, bl, core, sby_n, susp_n,
            video_clock_en, crtc_en, rdac_lp, rf_slow});
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'h1;
        @(negedge clk_sys);
        for (i = 0; i < 200 && bl !== 1'h1; i++) @(negedge clk_sys);
        chk("power up", 32'h7, {sup, con, bl});
        chk("up time", 32'h1, 32'(i >= 16 && i <= 24));
        for (i = 0; i < 6; i++) begin
            bus(rows[i].a, 1'h1, 32'(rows[i].d));
            bus(rows[i].a, 1'h0, 32'h0);
            @(negedge clk_sys);
            chk("readback", 32'(rows[i].r), rd);
            chk("hresp", 32'h0, 32'(hresp));
            chk("core sel", 32'(rows[i].c), core);
        end
        bus(32'h08, 1'h1, 32'h08);
        @(negedge clk_sys);
        chk("bl override", 32'h0, bl);
        bus(32'h08, 1'h1, 32'h00);
        bus(32'h00, 1'h1, 32'h10);
        @(negedge clk_sys);
        for (i = 0; i < 200 && sby_n !== 1'h0; i++) @(negedge clk_sys);
        chk("standby outs", 32'h03, {sup, con, bl, video_clock_en, crtc_en,
            rdac_lp, rf_slow});
        bus(32'h0C, 1'h0, 32'h0);
        chk("status reg", 32'h10, rd);
        bus(32'h08, 1'h1, 32'h03);
        @(negedge clk_sys);
        chk("sup override", 32'h1, sup);
        bus(32'h08, 1'h1, 32'h00);
        @(posedge clk_sys);
        sense <= 1'h1;
        bus(32'h00, 1'h1, 32'h00);
        repeat (1000) @(negedge clk_sys);
        chk("pin holds", 32'h0, sby_n);
        @(posedge clk_sys);
        sense <= 1'h0;
        repeat (400) @(negedge clk_sys);
        chk("status hold", 32'h0, sby_n);
        for (i = 0; i < 1000 && sby_n !== 1'h1; i++) @(negedge clk_sys);
        chk("status drop", 32'h1, sby_n);
        chk("hold time", 32'h1, 32'(i >= 395 && i <= 410));
        for (i = 0; i < 300 && bl !== 1'h1; i++) @(negedge clk_sys);
        chk("power back", 32'h7, {sup, con, bl});
        // CRT only powers the panel down without standby
        @(posedge clk_sys);
        lcd <= 1'h0;
        for (i = 0; i < 100 && sup !== 1'h0; i++) @(negedge clk_sys);
        chk("crt only", 32'h03, {sup, con, bl, sby_n, video_clock_en});
        @(posedge clk_sys);
        lcd <= 1'h1;
        for (i = 0; i < 100 && bl !== 1'h1; i++) @(negedge clk_sys);
        chk("lcd back", 32'h7, {sup, con, bl});
        // Backlight timer restarts from keyboard, access, activity edge
        bus(32'h20, 1'h1, 32'h01);
        bus(32'h10, 1'h1, 32'h0C);
        bus(32'h1C, 1'h1, 32'h80);
        bus(32'h18, 1'h1, 32'h40);
        bus(32'h04, 1'h1, 32'h10);
        for (j = 0; j < 3; j++) begin
            for (i = 0; i < 100 && bl !== 1'h0; i++) @(negedge clk_sys);
            chk("bl idle", 32'h1, 32'(i >= 1 && i <= 24));
            @(posedge clk_sys);
            {sense, host, kbd} <= 3'h1 << j;
            @(posedge clk_sys);
            {sense, host, kbd} <= 3'h0;
            for (i = 0; i < 6 && bl !== 1'h1; i++) @(negedge clk_sys);
            chk("bl restart", 32'h1, bl);
        end
        bus(32'h18, 1'h1, 32'h00);
        bus(32'h1C, 1'h1, 32'h00);
        bus(32'h04, 1'h1, 32'h01);
        @(negedge clk_sys);
        for (i = 0; i < 200 && sby_n !== 1'h0; i++) @(negedge clk_sys);
        chk("idle standby", 32'h1, 32'(i >= 15 && i < 200));
        @(posedge clk_sys);
        tft   <= 1'h1;
        green <= 2'h2;
        repeat (3) @(negedge clk_sys);
        chk("tft pins", 32'h1, {sby_n, susp_n});
        @(posedge clk_sys);
        tft  <= 1'h0;
        susp <= 2'h1;
        repeat (3) @(negedge clk_sys);
        chk("suspend pin", 32'h0, susp_n);
        bus(32'h1C, 1'h1, 32'h80);
        repeat (3) @(negedge clk_sys);
        chk("fc pins", 32'h3, {sby_n, susp_n});
        chk("panel order", 32'h0, fault);
        print_verdict();
    end
endmodule

// file: verification/lpm_panel_model.sv
// Panel supply switches model that flags power order faults
module lpm_panel_model (
    input  wire logic clk_sys,
    input  wire logic supply,
    input  wire logic contrast,
    input  wire logic backlight,
    output logic      order_fault
);
    timeunit 1ns;
    timeprecision 1ns;

    logic fault_seen = 1'h0;

    // Sticky so a short glitch is not lost
    assign order_fault = fault_seen;

    // order of rails
    // Contrast or lamp without the rail below it stresses the glass
    always @(posedge clk_sys) begin
        if ((contrast && !supply) || (backlight && !contrast)) begin
            fault_seen <= 1'h1;
        end
    end
endmodule
